// >>> src/ufc_pkg.sv
package ufc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GAIN = 8'h13;
  localparam logic [7:0] ADDR_FAULT = 8'h14;
  localparam logic [7:0] ADDR_SUPPLY = 8'h16;

  // Writable bits; reserved bits are never stored and read as zero
  localparam logic [7:0] GAIN_WR_MASK = 8'hC7;
  localparam logic [7:0] FAULT_WR_MASK = 8'h1F;
  localparam logic [7:0] SUPPLY_WR_MASK = 8'h7F;

  localparam logic [7:0] RST_GAIN = 8'h00;
  localparam logic [7:0] RST_FAULT = 8'h00;
  localparam logic [7:0] RST_SUPPLY = 8'h20;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  // Preamp gain codes 0..3 = 15, 10, 20, 12.5 V/V
  // Scale select 0 = 3.3 V range, 1 = 5.0 V range
  typedef struct packed {
    logic first_stage_off;
    logic last_stage_off;
    logic [2:0] rsvd;
    logic scale_sel;
    logic [1:0] preamp_gain;
  } ufc_gain_reg_type;

  typedef enum logic [1:0] {
    PIN_MODE_0 = 2'h0,
    PIN_MODE_1 = 2'h1,
    PIN_MODE_2 = 2'h2,
    PIN_MODE_3 = 2'h3
  } ufc_pin_mode_type;

  typedef struct packed {
    logic [2:0] rsvd;
    logic [2:0] pulse_fault_deglitch;
    ufc_pin_mode_type pin_mode;
  } ufc_fault_reg_type;

  // Pull-up code 0 = 10 mA, 1 = 20 mA; supply volts = code + 5
  typedef struct packed {
    logic rsvd;
    logic listen_auto_discharge;
    logic supply_high_impedance;
    logic supply_pullup_current;
    logic [3:0] supply_voltage_code;
  } ufc_supply_reg_type;

  // ----------------------------------------------------------------
  // Deglitch timing
  // ----------------------------------------------------------------
  localparam logic [2:0] DGL_OFF = 3'h7;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_DGL0_NS = 64000;
  localparam int T_DGL1_NS = 48000;
  localparam int T_DGL2_NS = 32000;
  localparam int T_DGL3_NS = 24000;
  localparam int T_DGL4_NS = 16000;
  localparam int T_DGL5_NS = 8000;
  localparam int T_DGL6_NS = 4000;
  localparam int DGL0_CYC = (T_DGL0_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DGL1_CYC = (T_DGL1_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DGL2_CYC = (T_DGL2_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DGL3_CYC = (T_DGL3_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DGL4_CYC = (T_DGL4_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DGL5_CYC = (T_DGL5_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DGL6_CYC = (T_DGL6_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // State carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CHK_IDLE = 2'b00,
    CHK_RUN = 2'b01
  } ufc_chk_state_type;

  typedef struct packed {
    ufc_chk_state_type st;
    logic burst_d;
    logic pa_d;
    logic pb_d;
    logic [15:0] cnt_a;
    logic [15:0] cnt_b;
    logic fault;
  } ufc_chk_type;

  localparam ufc_chk_type CHK_RST = '{st: CHK_IDLE, default: '0};

  typedef struct packed {
    ufc_gain_reg_type gain;
    ufc_fault_reg_type fault_cfg;
    ufc_supply_reg_type supply;
    logic sa1;
    logic sa2;
    logic sb1;
    logic sb2;
    logic burst;
    logic trig_d;
    logic charge;
    logic flag;
    logic [7:0] rdata;
  } ufc_main_type;

  localparam ufc_main_type MAIN_RST = '{
    gain: ufc_gain_reg_type'(RST_GAIN),
    fault_cfg: ufc_fault_reg_type'(RST_FAULT),
    supply: ufc_supply_reg_type'(RST_SUPPLY),
    default: '0
  };

endpackage

// >>> src/ufc_pulse_check.sv
`timescale 1ns/1ps
module ufc_pulse_check import ufc_pkg::*; #(
  parameter int P_DGL0_CYC = DGL0_CYC,
  parameter int P_DGL1_CYC = DGL1_CYC,
  parameter int P_DGL2_CYC = DGL2_CYC,
  parameter int P_DGL3_CYC = DGL3_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Synchronised burst pins and burst state
  input wire logic pin_a_i,
  input wire logic pin_b_i,
  input wire logic burst_i,
  // Configuration
  input wire ufc_pin_mode_type mode_i,
  input wire logic [2:0] deglitch_i,
  // One-cycle fault event
  output logic fault_o
);

  ufc_chk_type s_r;
  ufc_chk_type s_nxt;
  logic [15:0] limit;
  logic en;
  logic both_high;
  logic tog_a;
  logic tog_b;

  always_comb begin
    case (deglitch_i)
      3'h0: limit = 16'(P_DGL0_CYC);
      3'h1: limit = 16'(P_DGL1_CYC);
      3'h2: limit = 16'(P_DGL2_CYC);
      3'h3: limit = 16'(P_DGL3_CYC);
      3'h4: limit = 16'(DGL4_CYC);
      3'h5: limit = 16'(DGL5_CYC);
      3'h6: limit = 16'(DGL6_CYC);
      default: limit = 16'hFFFF;
    endcase
  end

  assign en = (deglitch_i != DGL_OFF) && (mode_i != PIN_MODE_3);
  assign both_high = (mode_i == PIN_MODE_2) && pin_a_i && pin_b_i;
  assign tog_a = pin_a_i ^ s_r.pa_d;
  assign tog_b = pin_b_i ^ s_r.pb_d;

  always_comb begin
    s_nxt = s_r;
    s_nxt.fault = 1'b0;
    s_nxt.burst_d = burst_i;
    s_nxt.pa_d = pin_a_i;
    s_nxt.pb_d = pin_b_i;
    case (s_r.st)
      CHK_IDLE: begin
        s_nxt.cnt_a = 16'h0000;
        s_nxt.cnt_b = 16'h0000;
        if (burst_i && !s_r.burst_d) begin
          s_nxt.st = CHK_RUN;
        end
      end
      CHK_RUN: begin
        if (!burst_i) begin
          s_nxt.st = CHK_IDLE;
        end else if (!en || both_high) begin
          s_nxt.cnt_a = 16'h0000;
          s_nxt.cnt_b = 16'h0000;
        end else begin
          // Counters saturate so one idle stretch gives one event
          s_nxt.cnt_b = tog_b ? 16'h0000 :
                        (s_r.cnt_b == limit) ? s_r.cnt_b : s_r.cnt_b + 16'h0001;
          if (mode_i == PIN_MODE_2) begin
            s_nxt.cnt_a = tog_a ? 16'h0000 :
                          (s_r.cnt_a == limit) ? s_r.cnt_a : s_r.cnt_a + 16'h0001;
          end else begin
            s_nxt.cnt_a = 16'h0000;
          end
          s_nxt.fault = (!tog_b && s_r.cnt_b == limit - 16'h0001) ||
                        (mode_i == PIN_MODE_2 && !tog_a &&
                         s_r.cnt_a == limit - 16'h0001);
        end
      end
      default: s_nxt = CHK_RST;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_r <= CHK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fault_o = s_r.fault;

  AST_FAULT_PIN_B: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (s_r.st == CHK_RUN && burst_i && en && !both_high && !tog_b &&
     s_r.cnt_b == limit - 16'h0001) |=> fault_o)
    else $error("idle burst pin b did not raise a fault");

  AST_BOTH_HIGH_QUIET: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (mode_i == PIN_MODE_2 && pin_a_i && pin_b_i) |=> !fault_o)
    else $error("fault raised while both pins high in mode 2");

  AST_CHECK_OFF: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (deglitch_i == DGL_OFF) |=> !fault_o)
    else $error("fault raised with check disabled");

  AST_FAULT_NEEDS_BURST: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    fault_o |-> $past(s_r.st) == CHK_RUN && $past(burst_i))
    else $error("fault raised outside a burst");

endmodule

// >>> src/ufc_ctrl_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - Gain register bit 7 powers down the first log amplifier stage.
// - Gain register bit 6 removes current from the last log amplifier stage.
// - Gain register bit 2 picks envelope range: 0 is 3.3 V, 1 is 5.0 V.
// - Gain bits 1:0 pick preamp gain 15, 10, 20, 12.5 V/V.
// - Deglitch bits 4:2 pick 64..4 us fault timeout; code 7 disables the check.
// - Pin modes 0 and 1: idle pin b beyond deglitch during burst raises fault.
// - Pin mode 2: either idle pin raises fault, except while both are high.
// - Pin mode bits 1:0 select one of four burst pin modes.
// - Listen auto-discharge with trigger low stops supply charging at burst end.
// - High-impedance bit, reset 1, turns off supply current and regulation.
// - Pull-up bit selects 10 mA when clear, 20 mA when set.
// - Supply voltage equals four-bit code plus 5 volts.
// - Charge trigger switches charging under auto-discharge; no effect in high impedance.
// - Command trigger starts or stops burst only in pin mode 0.
module ufc_ctrl_regs import ufc_pkg::*; #(
  parameter int P_DGL0_CYC = DGL0_CYC,
  parameter int P_DGL1_CYC = DGL1_CYC,
  parameter int P_DGL2_CYC = DGL2_CYC,
  parameter int P_DGL3_CYC = DGL3_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Configuration port
  input wire logic [7:0] cfg_addr_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  // Neighbouring control bits
  input wire logic cmd_trigger_i,
  input wire logic supply_charge_trigger_i,
  input wire logic pin_burst_i,
  input wire logic flag_clear_i,
  // Burst pins
  input wire logic burst_pin_a_i,
  input wire logic burst_pin_b_i,
  // Receiver controls
  output logic first_stage_off_o,
  output logic last_stage_off_o,
  output logic scale_sel_o,
  output logic [1:0] preamp_gain_o,
  // Burst and fault
  output logic [1:0] pin_mode_o,
  output logic burst_active_o,
  output logic pulse_fault_flag_o,
  // Drive supply controls
  output logic supply_high_impedance_o,
  output logic supply_pullup_current_o,
  output logic [3:0] supply_voltage_code_o,
  output logic supply_charge_en_o
);

  ufc_main_type s_r;
  ufc_main_type s_nxt;
  logic fault_pulse;
  logic burst_req;
  logic burst_rise;
  logic burst_fall;
  logic trig_fall;

  // ----------------------------------------------------------------
  // Fault check
  // ----------------------------------------------------------------
  ufc_pulse_check #(
    .P_DGL0_CYC(P_DGL0_CYC),
    .P_DGL1_CYC(P_DGL1_CYC),
    .P_DGL2_CYC(P_DGL2_CYC),
    .P_DGL3_CYC(P_DGL3_CYC)
  ) u_check (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pin_a_i(s_r.sa2),
    .pin_b_i(s_r.sb2),
    .burst_i(s_r.burst),
    .mode_i(s_r.fault_cfg.pin_mode),
    .deglitch_i(s_r.fault_cfg.pulse_fault_deglitch),
    .fault_o(fault_pulse)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Pins are asynchronous to the clock
    s_nxt.sa1 = burst_pin_a_i;
    s_nxt.sa2 = s_r.sa1;
    s_nxt.sb1 = burst_pin_b_i;
    s_nxt.sb2 = s_r.sb1;

    if (cfg_wr_i) begin
      case (cfg_addr_i)
        ADDR_GAIN: s_nxt.gain = ufc_gain_reg_type'(cfg_wdata_i & GAIN_WR_MASK);
        ADDR_FAULT: s_nxt.fault_cfg = ufc_fault_reg_type'(cfg_wdata_i & FAULT_WR_MASK);
        ADDR_SUPPLY: s_nxt.supply = ufc_supply_reg_type'(cfg_wdata_i & SUPPLY_WR_MASK);
        default: s_nxt.gain = s_r.gain;
      endcase
    end

    if (cfg_rd_i) begin
      case (cfg_addr_i)
        ADDR_GAIN: s_nxt.rdata = s_r.gain;
        ADDR_FAULT: s_nxt.rdata = s_r.fault_cfg;
        ADDR_SUPPLY: s_nxt.rdata = s_r.supply;
        default: s_nxt.rdata = RDATA_UNMAPPED;
      endcase
    end

    s_nxt.burst = burst_req;

    // Set beats a clear in the same cycle
    s_nxt.flag = fault_pulse | (s_r.flag & ~flag_clear_i);

    s_nxt.trig_d = supply_charge_trigger_i;
    if (s_r.supply.supply_high_impedance) begin
      s_nxt.charge = 1'b0;
    end else if (!s_r.supply.listen_auto_discharge) begin
      s_nxt.charge = 1'b1;
    end else if (supply_charge_trigger_i) begin
      s_nxt.charge = 1'b1;
    end else if (burst_rise) begin
      // Burst needs the supply even when it was discharged in listen
      s_nxt.charge = 1'b1;
    end else if (burst_fall || trig_fall) begin
      s_nxt.charge = 1'b0;
    end else begin
      s_nxt.charge = s_r.charge;
    end
  end

  // Pin-driven modes take the burst request from the pin decoder
  assign burst_req = (s_r.fault_cfg.pin_mode == PIN_MODE_0) ? cmd_trigger_i :
                     pin_burst_i;
  // Edges come from the request, so the charge logic never loops through s_nxt
  assign burst_rise = burst_req & ~s_r.burst;
  assign burst_fall = ~burst_req & s_r.burst;
  assign trig_fall = ~supply_charge_trigger_i & s_r.trig_d;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_r <= MAIN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cfg_rdata_o = s_r.rdata;
  assign first_stage_off_o = s_r.gain.first_stage_off;
  assign last_stage_off_o = s_r.gain.last_stage_off;
  assign scale_sel_o = s_r.gain.scale_sel;
  assign preamp_gain_o = s_r.gain.preamp_gain;
  assign pin_mode_o = s_r.fault_cfg.pin_mode;
  assign burst_active_o = s_r.burst;
  assign pulse_fault_flag_o = s_r.flag;
  assign supply_high_impedance_o = s_r.supply.supply_high_impedance;
  assign supply_pullup_current_o = s_r.supply.supply_pullup_current;
  assign supply_voltage_code_o = s_r.supply.supply_voltage_code;
  assign supply_charge_en_o = s_r.charge;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_FIRST_STAGE: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (cfg_wr_i && cfg_addr_i == ADDR_GAIN) |=> first_stage_off_o == $past(cfg_wdata_i[7]))
    else $error("first stage control did not follow write");

  AST_LAST_STAGE: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (cfg_wr_i && cfg_addr_i == ADDR_GAIN) |=> last_stage_off_o == $past(cfg_wdata_i[6]))
    else $error("last stage control did not follow write");

  AST_SCALE_GAIN: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (cfg_wr_i && cfg_addr_i == ADDR_GAIN) |=>
      {scale_sel_o, preamp_gain_o} == $past(cfg_wdata_i[2:0]) ##1
      (!$past(cfg_rd_i) || $past(cfg_addr_i) != ADDR_GAIN || cfg_rdata_o[5:3] == 3'h0))
    else $error("scale or preamp gain did not follow write");

  AST_PREAMP_HOLD: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    !(cfg_wr_i && cfg_addr_i == ADDR_GAIN) |=> $stable(preamp_gain_o))
    else $error("preamp gain changed without a write");

  AST_PIN_MODE_READ: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (cfg_rd_i && cfg_addr_i == ADDR_FAULT) |=> cfg_rdata_o[1:0] == $past(pin_mode_o))
    else $error("pin mode readback mismatch");

  AST_HIZ_NO_CHARGE: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    supply_high_impedance_o |=> !supply_charge_en_o)
    else $error("supply charging while high impedance");

  AST_SUPPLY_FIELDS: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (cfg_wr_i && cfg_addr_i == ADDR_SUPPLY) |=>
      {supply_pullup_current_o, supply_voltage_code_o} == $past(cfg_wdata_i[4:0]))
    else $error("supply fields did not follow write");

  AST_LISTEN_OFF: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (burst_fall && s_r.supply.listen_auto_discharge && !supply_charge_trigger_i &&
     !supply_high_impedance_o) |=> !supply_charge_en_o)
    else $error("charging not stopped after burst in listen");

  AST_TRIGGER_ON: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (supply_charge_trigger_i && !supply_high_impedance_o) |=> supply_charge_en_o)
    else $error("charge trigger did not enable charging");

  AST_CMD_MODE: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (pin_mode_o != PIN_MODE_0) |=> burst_active_o == $past(pin_burst_i))
    else $error("command trigger not ignored outside mode 0");

  AST_FLAG_SET_WINS: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    fault_pulse |=> pulse_fault_flag_o)
    else $error("fault event lost");

endmodule

// >>> testbench/ufc_mcu_model.sv
`timescale 1ns/1ps
module ufc_mcu_model #(
  parameter int TOGGLE_CYC = 10
) (
  // Clock
  input wire logic clk_i,
  // Pattern controls from the bench
  input wire logic run_a_i,
  input wire logic run_b_i,
  input wire logic hold_hi_i,
  // Burst pins
  output logic burst_pin_a_o,
  output logic burst_pin_b_o
);
  int cnt = 0;
  logic a_r = 1'b0;
  logic b_r = 1'b0;

  // ----------------------------------------------------------------
  // Pin pattern
  // ----------------------------------------------------------------
  // Interval must stay below the shortest deglitch count in use
  always @(negedge clk_i) begin
    cnt <= (cnt == TOGGLE_CYC - 1) ? 0 : cnt + 1;
    // Stopped pin rests low, so mode 2 never mistakes it for both pins high
    if (!run_a_i) begin
      a_r <= 1'b0;
    end else if (cnt == 0) begin
      a_r <= ~a_r;
    end
    if (!run_b_i) begin
      b_r <= 1'b0;
    end else if (cnt == 0) begin
      b_r <= ~b_r;
    end
  end

  // Hold-high parks both pins high for the mode 2 exemption
  assign burst_pin_a_o = hold_hi_i | a_r;
  assign burst_pin_b_o = hold_hi_i | b_r;
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top import ufc_pkg::*; ();
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] cfg_addr_i = 8'h00;
  logic cfg_wr_i = 1'b0;
  logic cfg_rd_i = 1'b0;
  logic [7:0] cfg_wdata_i = 8'h00;
  logic cmd_trigger_i = 1'b0;
  logic supply_charge_trigger_i = 1'b0;
  logic pin_burst_i = 1'b0;
  logic flag_clear_i = 1'b0;
  logic run_a = 1'b1;
  logic run_b = 1'b1;
  logic hold_hi = 1'b0;
  logic pin_a, pin_b, first_stage_off_o, last_stage_off_o, scale_sel_o;
  logic burst_active_o, pulse_fault_flag_o, supply_charge_en_o;
  logic supply_high_impedance_o, supply_pullup_current_o;
  logic [1:0] preamp_gain_o, pin_mode_o;
  logic [3:0] supply_voltage_code_o;
  logic [7:0] cfg_rdata_o, rd_v, d;
  logic [7:0] sh[3] = '{8'h00, 8'h00, 8'h20};
  int n_errors = 0;
  int tests_run = 0;
  int seed = 26294;
  localparam logic [7:0] ADDRS[4] = '{ADDR_GAIN, ADDR_FAULT, ADDR_SUPPLY, 8'h15};
  localparam int FM[7] = '{0, 1, 2, 2, 3, 0, 0};
  localparam int FC[7] = '{3, 2, 2, 1, 0, 7, 6};
  localparam int FL[7] = '{15, 20, 20, 30, 40, 40, 800};
  localparam logic [6:0] FA = 7'h41;
  localparam logic [6:0] FB = 7'h06;
  localparam logic [6:0] FH = 7'h08;
  localparam logic [6:0] FF = 7'h45;

  always #2.5 clk_i = ~clk_i;

  ufc_ctrl_regs #(.P_DGL0_CYC(40), .P_DGL1_CYC(30), .P_DGL2_CYC(20), .P_DGL3_CYC(15)) u_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_addr_i(cfg_addr_i), .cfg_wr_i(cfg_wr_i),
    .cfg_rd_i(cfg_rd_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
    .cmd_trigger_i(cmd_trigger_i), .supply_charge_trigger_i(supply_charge_trigger_i),
    .pin_burst_i(pin_burst_i), .flag_clear_i(flag_clear_i), .burst_pin_a_i(pin_a),
    .burst_pin_b_i(pin_b), .first_stage_off_o(first_stage_off_o),
    .last_stage_off_o(last_stage_off_o), .scale_sel_o(scale_sel_o),
    .preamp_gain_o(preamp_gain_o), .pin_mode_o(pin_mode_o), .burst_active_o(burst_active_o),
    .pulse_fault_flag_o(pulse_fault_flag_o), .supply_high_impedance_o(supply_high_impedance_o),
    .supply_pullup_current_o(supply_pullup_current_o),
    .supply_voltage_code_o(supply_voltage_code_o), .supply_charge_en_o(supply_charge_en_o)
  );

  ufc_mcu_model u_mcu (
    .clk_i(clk_i), .run_a_i(run_a), .run_b_i(run_b), .hold_hi_i(hold_hi),
    .burst_pin_a_o(pin_a), .burst_pin_b_o(pin_b)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] exp_reg(input logic [7:0] a, input logic [7:0] v);
    case (a)
      ADDR_GAIN: return v & GAIN_WR_MASK;
      ADDR_FAULT: return v & FAULT_WR_MASK;
      ADDR_SUPPLY: return v & SUPPLY_WR_MASK;
      default: return RDATA_UNMAPPED;
    endcase
  endfunction

  function automatic logic [7:0] b8(input logic x);
    return {7'h00, x};
  endfunction

  task automatic go(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Strobe dropped and one edge let pass, so calls can follow each other
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    cfg_addr_i = a;
    cfg_wdata_i = v;
    cfg_wr_i = 1'b1;
    go(1);
    cfg_wr_i = 1'b0;
    go(1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    cfg_addr_i = a;
    cfg_rd_i = 1'b1;
    go(1);
    cfg_rd_i = 1'b0;
    go(1);
    v = cfg_rdata_o;
  endtask

  task automatic out_chk();
    logic [7:0] g;
    logic [7:0] s;
    g = {first_stage_off_o, last_stage_off_o, 3'h0, scale_sel_o, preamp_gain_o};
    s = {2'h0, supply_high_impedance_o, supply_pullup_current_o, supply_voltage_code_o};
    chk("gain_outs", g, sh[0]);
    chk("mode_outs", {6'h00, pin_mode_o}, sh[1] & 8'h03);
    chk("supply_outs", s, sh[2] & 8'h3F);
  endtask

  task automatic idle_check(input int lim, input logic fires);
    go(lim - 4);
    chk("flag_early", b8(pulse_fault_flag_o), 8'h00);
    go(14);
    chk("flag_late", b8(pulse_fault_flag_o), b8(fires));
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    conclude();
  end

  initial begin
    go(20);
    rst_b_i = 1'b1;
    chk("reset_outs_a", {first_stage_off_o, last_stage_off_o, scale_sel_o, preamp_gain_o,
        burst_active_o, pulse_fault_flag_o, supply_high_impedance_o}, 8'h01);
    chk("reset_outs_b", {pin_mode_o, supply_pullup_current_o, supply_voltage_code_o,
        supply_charge_en_o}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(ADDRS[i], rd_v);
      chk("reset_read", rd_v, (i < 3) ? sh[i] : RDATA_UNMAPPED);
    end
    // Unmapped address mixed in: its write must leave every output alone
    for (int i = 0; i < 24; i++) begin
      d = 8'($random(seed));
      wr(ADDRS[i % 4], d);
      if (i % 4 < 3) begin
        sh[i % 4] = exp_reg(ADDRS[i % 4], d);
      end
      out_chk();
      rd(ADDRS[i % 4], rd_v);
      chk("readback", rd_v, exp_reg(ADDRS[i % 4], d));
    end
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_FAULT, {3'h0, 3'h7, 2'(m)});
      cmd_trigger_i = 1'b1;
      go(3);
      chk("burst_cmd", b8(burst_active_o), b8(m == 0));
      cmd_trigger_i = 1'b0;
      pin_burst_i = 1'b1;
      go(3);
      chk("burst_pin", b8(burst_active_o), b8(m != 0));
      pin_burst_i = 1'b0;
      go(3);
    end
    for (int k = 0; k < 7; k++) begin
      run_a = FA[k];
      run_b = FB[k];
      hold_hi = FH[k];
      wr(ADDR_FAULT, {3'h0, 3'(FC[k]), 2'(FM[k])});
      cmd_trigger_i = 1'b1;
      pin_burst_i = 1'b1;
      idle_check(FL[k], FF[k]);
      cmd_trigger_i = 1'b0;
      pin_burst_i = 1'b0;
      go(3);
      chk("flag_sticky", b8(pulse_fault_flag_o), b8(FF[k]));
      flag_clear_i = 1'b1;
      go(1);
      flag_clear_i = 1'b0;
      go(2);
      chk("flag_clear", b8(pulse_fault_flag_o), 8'h00);
    end
    run_a = 1'b1;
    run_b = 1'b1;
    hold_hi = 1'b0;
    wr(ADDR_FAULT, 8'h0C);
    cmd_trigger_i = 1'b1;
    go(60);
    chk("flag_toggling", b8(pulse_fault_flag_o), 8'h00);
    @(pin_b);
    @(negedge clk_i);
    run_b = 1'b0;
    idle_check(15, 1'b1);
    cmd_trigger_i = 1'b0;
    flag_clear_i = 1'b1;
    go(1);
    flag_clear_i = 1'b0;
    wr(ADDR_FAULT, 8'h1C);
    wr(ADDR_SUPPLY, 8'h40);
    cmd_trigger_i = 1'b1;
    go(3);
    chk("charge_burst", b8(supply_charge_en_o), 8'h01);
    cmd_trigger_i = 1'b0;
    go(3);
    chk("charge_after", b8(supply_charge_en_o), 8'h00);
    supply_charge_trigger_i = 1'b1;
    go(3);
    chk("charge_trig_on", b8(supply_charge_en_o), 8'h01);
    supply_charge_trigger_i = 1'b0;
    go(3);
    chk("charge_trig_off", b8(supply_charge_en_o), 8'h00);
    supply_charge_trigger_i = 1'b1;
    wr(ADDR_SUPPLY, 8'h60);
    go(3);
    chk("charge_hiz", b8(supply_charge_en_o), 8'h00);
    wr(ADDR_SUPPLY, 8'h00);
    go(3);
    chk("charge_no_listen", b8(supply_charge_en_o), 8'h01);
    conclude();
  end
endmodule
